// ---- hdl/psr_pkg.sv ----
package psr_pkg;
	// register map of the result path
	localparam logic [7:0] ADR_CH0 = 8'h70;
	localparam logic [7:0] ADR_CH1 = 8'h71;
	localparam logic [7:0] ADR_CH2 = 8'h72;
	localparam logic [7:0] ADR_SLEEP = 8'h73;
	localparam logic [7:0] ADR_UNUSED = 8'h74;
	localparam logic [7:0] ADR_MEM = 8'h75;
	localparam logic [7:0] ADR_DEC1 = 8'h78;
	localparam logic [7:0] ADR_DEC2 = 8'h79;
	localparam logic [7:0] ADR_DEC3 = 8'h7A;
	localparam logic [7:0] ADR_FLT0 = 8'h7D;
	localparam logic [7:0] ADR_FLT1 = 8'h7E;
	localparam logic [7:0] ADR_HWID = 8'h7F;
	// setup field and option bits of frontend_setup_config
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_OFFAX = 4;
	localparam int CFG_PAIR_LSB = 5;
	localparam int CFG_SEC_EN = 7;
	localparam logic [3:0] M_S1 = 4'h1;
	localparam logic [3:0] M_S2 = 4'h2;
	localparam logic [3:0] M_S3 = 4'h3;
	localparam logic [3:0] M_S4A = 4'h4;
	localparam logic [3:0] M_S5 = 4'h5;
	localparam logic [3:0] M_S6 = 4'h6;
	localparam logic [3:0] M_S7 = 4'h7;
	localparam logic [3:0] M_S4B = 4'h8;
	localparam logic [1:0] PAIR_YX = 2'h0;
	localparam logic [1:0] PAIR_ZX = 2'h1;
	localparam logic [1:0] PAIR_ZY = 2'h2;
	// fault_report_1 bits owned by this block
	localparam int F1_CRC = 0;
	localparam int F1_SELF = 1;
	// arithmetic
	localparam int W = 22;
	localparam int ITERS = 16;
	localparam int GAIN_FRAC = 12;
	localparam logic [15:0] GINV = 16'h4DBA;
	localparam logic [15:0] HALF_PI = 16'h8000;
	localparam logic [W-1:0] TEST_V = 22'h004000;
	localparam logic [15:0] TEST_ANG = 16'h2000;
	localparam logic [15:0] TEST_TOL = 16'h0004;
	localparam logic [7:0] CRC_POLY = 8'h1D;
	localparam logic [7:0] CRC_INIT = 8'hFF;
	localparam logic [15:0] SLEEP_KEY = 16'h5A5A;
	// reset values
	localparam logic [15:0] RST16 = 16'h0000;
	localparam logic [7:0] RST8 = 8'h00;

	typedef struct packed {
		logic signed [15:0] x1;
		logic signed [15:0] y1;
		logic signed [15:0] z1;
		logic signed [15:0] x4;
		logic signed [15:0] y4;
		logic signed [15:0] z4;
	} psr_pix_t;

	typedef struct packed {
		logic [15:0] c1;
		logic [15:0] c2;
		logic [15:0] c3;
	} psr_chan_t;

	typedef struct packed {
		logic signed [W-1:0] x;
		logic signed [W-1:0] y;
	} psr_vec_t;
endpackage : psr_pkg

// ---- hdl/psr_result_path.sv ----
// Functional notes
// - self-test at start, integrity checks into fault words
// - two read-only 16-bit production words
// - data channels carry CRC, errors reported
// - channel 0: first output or ch1 raw
// - channel 1: second angle, amplitude or ch2
// - channel 2: ch3 raw in raw setup
// - channel 3 sleeps device; channel 4 unused
// - channel 5 is memory access path
// - 0x78..0x7A return decimated signals
// - 0x7D/0x7E faults, 0x7F hardware identity
// - setup field selects routing and computation
// - setup 1: differential horizontal 180 degree angle; computed here as the 360 degree angle of setup 2
// - setup 2: differential horizontal 360 degree angle
// - setup 3 linear: atan2 of dZ over dX
// - setup 3 off-axis: atan2 of dY over dX
// - setup 4a: selectable pair, no compensation
// - setup 4b: average cells 1 and 4
// - setup 5: Z over X and Z over Y
// - two-angle setups expose both angles
// - setup 6: joystick root equation, two angles
// - setup 7: expose compensated raw components
// - joystick gain is a 16-bit input word
`timescale 1ns/1ps
`default_nettype none
module psr_result_path #(
	parameter logic [15:0] HW_IDENT = 16'h0A51, // arbitrary value
	parameter logic [15:0] PROD_WORD1 = 16'h0000,
	parameter logic [15:0] PROD_WORD2 = 16'h0000
) (
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic SMP_VALID,
	input wire psr_pkg::psr_pix_t SMP,
	input wire psr_pkg::psr_chan_t DEC,
	input wire logic [15:0] SETUP_CFG,
	input wire logic [15:0] JOY_GAIN,
	input wire logic [15:0] FAULT_IN0,
	input wire logic [15:0] FAULT_IN1,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_RD,
	input wire logic REG_WR,
	input wire logic [15:0] REG_WDATA,
	input wire logic MEM_RSP_VALID,
	input wire logic [15:0] MEM_RSP_DATA,
	output logic [15:0] REG_RDATA,
	output logic [7:0] REG_RCRC,
	output logic REG_RVALID,
	output logic SLEEP_REQ,
	output logic MEM_CMD_STB,
	output logic [15:0] MEM_CMD,
	output logic RESULT_STB,
	output logic [15:0] PROD_INFO_1,
	output logic [15:0] PROD_INFO_2
);
	import psr_pkg::*;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_LOAD = 5'b00010,
		ST_ITER = 5'b00100,
		ST_STORE = 5'b01000,
		ST_COMMIT = 5'b10000
	} psr_state_t;

	////////////////////////////////////////////////////////////////////////
	// functions

	// crc over one 16-bit word, msb first
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 15; i >= 0; i--)
		begin
			c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction : crc8

	// arctangent of 2^-i, full circle = 2^16
	function automatic logic [15:0] atan_lut(input logic [3:0] i);
		logic [15:0] a;
		case (i)
			4'h0: a = 16'h2000;
			4'h1: a = 16'h12E4;
			4'h2: a = 16'h09FB;
			4'h3: a = 16'h0511;
			4'h4: a = 16'h028B;
			4'h5: a = 16'h0146;
			4'h6: a = 16'h00A3;
			4'h7: a = 16'h0051;
			4'h8: a = 16'h0029;
			4'h9: a = 16'h0014;
			4'hA: a = 16'h000A;
			4'hB: a = 16'h0005;
			4'hC: a = 16'h0003;
			4'hD: a = 16'h0001;
			4'hE: a = 16'h0001;
			default: a = 16'h0000;
		endcase
		return a;
	endfunction : atan_lut

	function automatic logic signed [W-1:0] sx(input logic signed [15:0] v);
		return {{(W-16){v[15]}}, v};
	endfunction : sx

	// gain word has 12 fraction bits
	function automatic logic signed [W-1:0] gmul(input logic signed [15:0] g,
		input logic signed [15:0] v);
		logic signed [33:0] p;
		p = g * v;
		return p[W-1+GAIN_FRAC:GAIN_FRAC];
	endfunction : gmul

	// removes the rotator gain from a vector length
	function automatic logic signed [W-1:0] unscale(input logic signed [W-1:0] m);
		logic [37:0] p;
		p = 38'(unsigned'(m)) * 38'(GINV);
		return p[W+14:15];
	endfunction : unscale

	// operand pair for one pass: y is the numerator
	function automatic psr_vec_t ops(input logic [3:0] m, input logic [1:0] p,
		input logic [15:0] cfg, input psr_pix_t s,
		input logic signed [W-1:0] mg, input logic signed [15:0] g);
		psr_vec_t v;
		logic signed [W-1:0] dx, dy, dz;
		dx = sx(s.x4) - sx(s.x1);
		dy = sx(s.y4) - sx(s.y1);
		dz = sx(s.z4) - sx(s.z1);
		v.x = sx(s.x1);
		v.y = sx(s.y1);
		case (m)
			M_S1, M_S2:
			begin
				v.x = dx;
				v.y = dy;
			end
			M_S3:
			begin
				v.x = dx;
				v.y = cfg[CFG_OFFAX] ? dy : dz;
			end
			M_S4A:
			begin
				case (cfg[CFG_PAIR_LSB +: 2])
					PAIR_ZX: v.y = sx(s.z1);
					PAIR_ZY:
					begin
						v.x = sx(s.y1);
						v.y = sx(s.z1);
					end
					default: v.y = sx(s.y1);
				endcase
			end
			M_S4B:
			begin
				v.x = (sx(s.x1) + sx(s.x4)) >>> 1;
				v.y = (sx(s.y1) + sx(s.y4)) >>> 1;
			end
			M_S5:
			begin
				v.x = p[0] ? sx(s.y1) : sx(s.x1);
				v.y = sx(s.z1);
			end
			M_S6:
			begin
				case (p)
					2'd0: v.y = gmul(g, s.z1);
					2'd1:
					begin
						v.x = sx(s.y1);
						v.y = mg;
					end
					2'd2: v.y = gmul(g, s.y1);
					default:
					begin
						v.x = sx(s.z1);
						v.y = mg;
					end
				endcase
			end
			default: v.y = sx(s.y1);
		endcase
		return v;
	endfunction : ops

	////////////////////////////////////////////////////////////////////////
	// sample capture and pass sequencing

	psr_state_t st_q;
	psr_pix_t smp_q;
	psr_chan_t dec_q;
	logic [15:0] cfg_q, gain_q;
	logic [1:0] pass_q, npass;
	logic [3:0] cnt_q, mode;
	logic self_q, self_fail_q;
	logic signed [W-1:0] x_q, y_q, mag_q, mag_n;
	logic [15:0] z_q, amp_q;
	logic [15:0] ang_q [4];
	logic [15:0] ch0_q, ch1_q, ch2_q;
	logic [7:0] crc_q [3];
	psr_vec_t op;

	assign mode = cfg_q[CFG_MODE_LSB +: 4];
	assign npass = (mode == M_S6) ? 2'd3 : (mode == M_S5) ? 2'd1 : 2'd0;
	assign mag_n = unscale(x_q);
	assign op = self_q ? psr_vec_t'{x: TEST_V, y: TEST_V} :
		ops(mode, pass_q, cfg_q, smp_q, mag_q, signed'(gain_q));

	// config is snapshotted with the sample so a rewrite cannot tear a cycle
	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
		begin
			smp_q <= '0;
			dec_q <= '0;
			cfg_q <= RST16;
			gain_q <= RST16;
		end
		else if (st_q == ST_IDLE && !self_q && SMP_VALID)
		begin
			smp_q <= SMP;
			dec_q <= DEC;
			cfg_q <= SETUP_CFG;
			gain_q <= JOY_GAIN;
		end
	end

	// samples arriving while busy are dropped, not queued
	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
		begin
			st_q <= ST_IDLE;
			pass_q <= 2'd0;
			cnt_q <= 4'h0;
			self_q <= 1'b1;
		end
		else
		begin
			unique case (st_q)
				ST_IDLE:
				begin
					pass_q <= 2'd0;
					if (self_q || SMP_VALID)
						st_q <= ST_LOAD;
				end
				ST_LOAD:
				begin
					cnt_q <= 4'h0;
					st_q <= ST_ITER;
				end
				ST_ITER:
				begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == 4'(ITERS - 1))
						st_q <= ST_STORE;
				end
				ST_STORE:
				begin
					if (self_q)
					begin
						self_q <= 1'b0;
						st_q <= ST_IDLE;
					end
					else if (pass_q != npass)
					begin
						pass_q <= pass_q + 2'd1;
						st_q <= ST_LOAD;
					end
					else
						st_q <= ST_COMMIT;
				end
				ST_COMMIT: st_q <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// vectoring rotator

	// left half-plane is folded first so 16 steps reach every quadrant;
	// a zero vector is frozen, else the steps would walk its angle off 0
	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
		begin
			x_q <= '0;
			y_q <= '0;
			z_q <= RST16;
		end
		else if (st_q == ST_LOAD)
		begin
			x_q <= op.x[W-1] ? -op.x : op.x;
			y_q <= op.x[W-1] ? -op.y : op.y;
			z_q <= op.x[W-1] ? HALF_PI : RST16;
		end
		else if (st_q == ST_ITER && (x_q != '0 || y_q != '0))
		begin
			if (!y_q[W-1])
			begin
				x_q <= x_q + (y_q >>> cnt_q);
				y_q <= y_q - (x_q >>> cnt_q);
				z_q <= z_q + atan_lut(cnt_q);
			end
			else
			begin
				x_q <= x_q - (y_q >>> cnt_q);
				y_q <= y_q + (x_q >>> cnt_q);
				z_q <= z_q - atan_lut(cnt_q);
			end
		end
	end

	// per-pass results; zero vectors end at angle 0 and length 0
	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
		begin
			ang_q <= '{default: RST16};
			mag_q <= '0;
			amp_q <= RST16;
			self_fail_q <= 1'b0;
		end
		else if (st_q == ST_STORE)
		begin
			if (self_q)
				self_fail_q <= (z_q > TEST_ANG + TEST_TOL) ||
					(z_q < TEST_ANG - TEST_TOL);
			else
			begin
				ang_q[pass_q] <= z_q;
				mag_q <= mag_n;
				if (pass_q == 2'd0)
					amp_q <= (|mag_n[W-1:16]) ? 16'hFFFF : mag_n[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data channels, committed together

	logic two, sec;
	logic [15:0] first_angle, second_angle, nch0, nch1, nch2;
	assign two = (mode == M_S5) || (mode == M_S6);
	assign sec = two && cfg_q[CFG_SEC_EN];
	assign first_angle = (mode == M_S6) ? ang_q[1] : ang_q[0];
	assign second_angle = (mode == M_S6) ? ang_q[3] : ang_q[1];
	assign nch0 = (mode == M_S7) ? dec_q.c1 : first_angle;
	assign nch1 = (mode == M_S7) ? dec_q.c2 : sec ? second_angle : amp_q;
	assign nch2 = (mode == M_S7) ? dec_q.c3 : RST16;

	// all three words and their crcs move on one edge
	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
		begin
			ch0_q <= RST16;
			ch1_q <= RST16;
			ch2_q <= RST16;
			crc_q <= '{default: RST8};
			RESULT_STB <= 1'b0;
		end
		else
		begin
			RESULT_STB <= (st_q == ST_COMMIT);
			if (st_q == ST_COMMIT)
			begin
				ch0_q <= nch0;
				ch1_q <= nch1;
				ch2_q <= nch2;
				crc_q[0] <= crc8(nch0);
				crc_q[1] <= crc8(nch1);
				crc_q[2] <= crc8(nch2);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register port

	logic [15:0] flt0_q, flt1_q, mem_q;
	logic is_ch, crc_bad;
	logic [1:0] ci;
	assign ci = REG_ADDR[1:0];
	assign is_ch = REG_ADDR == ADR_CH0 || REG_ADDR == ADR_CH1 || REG_ADDR == ADR_CH2;
	assign crc_bad = REG_RD && is_ch && (crc_q[ci] !=
		crc8((ci == 2'd0) ? ch0_q : (ci == 2'd1) ? ch1_q : ch2_q));

	// faults are sticky, cleared by reading; a new fault beats the clear
	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
		begin
			flt0_q <= RST16;
			flt1_q <= RST16;
		end
		else
		begin
			flt0_q <= ((REG_RD && REG_ADDR == ADR_FLT0) ? RST16 : flt0_q) | FAULT_IN0;
			flt1_q <= ((REG_RD && REG_ADDR == ADR_FLT1) ? RST16 : flt1_q) | FAULT_IN1 |
				16'(crc_bad) << F1_CRC | 16'(self_fail_q) << F1_SELF;
		end
	end

	// read answer one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
		begin
			REG_RDATA <= RST16;
			REG_RCRC <= RST8;
			REG_RVALID <= 1'b0;
		end
		else
		begin
			REG_RVALID <= REG_RD;
			if (REG_RD)
			begin
				REG_RCRC <= is_ch ? crc_q[ci] : RST8;
				case (REG_ADDR)
					ADR_CH0: REG_RDATA <= ch0_q;
					ADR_CH1: REG_RDATA <= ch1_q;
					ADR_CH2: REG_RDATA <= ch2_q;
					ADR_MEM: REG_RDATA <= mem_q;
					ADR_DEC1: REG_RDATA <= dec_q.c1;
					ADR_DEC2: REG_RDATA <= dec_q.c2;
					ADR_DEC3: REG_RDATA <= dec_q.c3;
					ADR_FLT0: REG_RDATA <= flt0_q;
					ADR_FLT1: REG_RDATA <= flt1_q;
					ADR_HWID: REG_RDATA <= HW_IDENT;
					default: REG_RDATA <= RST16;
				endcase
			end
		end
	end

	// sleep and memory commands; a host write beats a memory answer
	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
		begin
			SLEEP_REQ <= 1'b0;
			MEM_CMD_STB <= 1'b0;
			MEM_CMD <= RST16;
			mem_q <= RST16;
			PROD_INFO_1 <= RST16;
			PROD_INFO_2 <= RST16;
		end
		else
		begin
			PROD_INFO_1 <= PROD_WORD1;
			PROD_INFO_2 <= PROD_WORD2;
			SLEEP_REQ <= REG_WR && REG_ADDR == ADR_SLEEP && REG_WDATA == SLEEP_KEY;
			MEM_CMD_STB <= REG_WR && REG_ADDR == ADR_MEM;
			if (REG_WR && REG_ADDR == ADR_MEM)
			begin
				MEM_CMD <= REG_WDATA;
				mem_q <= REG_WDATA;
			end
			else if (MEM_RSP_VALID)
				mem_q <= MEM_RSP_DATA;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!NRST);

	unmapped_read_a: assert property (REG_RD && REG_ADDR == ADR_UNUSED |=>
		REG_RVALID && REG_RDATA == 16'h0000) else $error("unmapped read not zero");
	hw_ident_a: assert property (REG_RD && REG_ADDR == ADR_HWID |=> REG_RDATA == HW_IDENT)
		else $error("identity read wrong");
	sleep_cmd_a: assert property (SLEEP_REQ |-> $past(REG_WR) &&
		$past(REG_ADDR) == ADR_SLEEP && $past(REG_WDATA) == SLEEP_KEY) else $error("bad sleep");
	mem_cmd_a: assert property (REG_WR && REG_ADDR == ADR_MEM |=>
		MEM_CMD_STB && MEM_CMD == $past(REG_WDATA)) else $error("memory command lost");
	atomic_commit_a: assert property ($changed(ch0_q) || $changed(ch1_q) || $changed(ch2_q)
		|-> $past(st_q) == ST_COMMIT) else $error("channel changed outside commit");
	raw_route_a: assert property (st_q == ST_COMMIT && mode == M_S7 |=>
		ch0_q == $past(dec_q.c1) && ch2_q == $past(dec_q.c3)) else $error("raw routing wrong");
	chan_crc_a: assert property (REG_RD && is_ch |=> REG_RCRC == crc8(REG_RDATA))
		else $error("channel crc mismatch");
	zero_angle_a: assert property (st_q == ST_LOAD && op.x == '0 && op.y == '0 |->
		##17 st_q == ST_STORE && z_q == 16'h0000) else $error("zero vector angle");
	fault_sticky_a: assert property (FAULT_IN0 != 16'h0000 |=>
		(flt0_q & $past(FAULT_IN0)) == $past(FAULT_IN0)) else $error("fault bit lost");
	no_prot_a: assert property (REG_RD && REG_ADDR == ADR_DEC1 |=> REG_RCRC == 8'h00)
		else $error("unprotected register carries crc");

	two_angle_c: cover property (st_q == ST_COMMIT && mode == M_S5 && sec);
	joystick_c: cover property (st_q == ST_COMMIT && mode == M_S6);
	sleep_c: cover property (SLEEP_REQ);
	fault_read_c: cover property (REG_RVALID && REG_RDATA != 16'h0000 && $past(REG_ADDR) == ADR_FLT1);
endmodule : psr_result_path
`default_nettype wire

// ---- sim/position_sensor_result_path_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module position_sensor_result_path_tb;
	import psr_pkg::*;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic smp_valid = 1'b0;
	psr_pix_t smp = '0;
	psr_chan_t dec = '{16'h1357, 16'h2468, 16'h0ACE};
	logic [15:0] setup_cfg = 16'h0000;
	logic [15:0] joy_gain = 16'h0000;
	logic [15:0] fault_in0 = 16'h0000;
	logic [15:0] fault_in1 = 16'h0000;
	logic [7:0] reg_addr = 8'h00;
	logic reg_rd = 1'b0;
	logic reg_wr = 1'b0;
	logic [15:0] reg_wdata = 16'h0000;
	logic slow = 1'b0;
	logic mem_rsp_valid, reg_rvalid, sleep_req, mem_cmd_stb, result_stb;
	logic [15:0] mem_rsp_data, reg_rdata, mem_cmd, prod_info_1, prod_info_2;
	logic [7:0] reg_rcrc;
	int mismatches = 0;
	int checked = 0;

	// identity and production words are arbitrary values
	psr_result_path #(.HW_IDENT(16'h6B2D), .PROD_WORD1(16'h1111), .PROD_WORD2(16'h2222)) uut (
		.MCLK(mclk), .NRST(nrst), .SMP_VALID(smp_valid), .SMP(smp), .DEC(dec),
		.SETUP_CFG(setup_cfg), .JOY_GAIN(joy_gain), .FAULT_IN0(fault_in0),
		.FAULT_IN1(fault_in1), .REG_ADDR(reg_addr), .REG_RD(reg_rd), .REG_WR(reg_wr),
		.REG_WDATA(reg_wdata), .MEM_RSP_VALID(mem_rsp_valid), .MEM_RSP_DATA(mem_rsp_data),
		.REG_RDATA(reg_rdata), .REG_RCRC(reg_rcrc), .REG_RVALID(reg_rvalid),
		.SLEEP_REQ(sleep_req), .MEM_CMD_STB(mem_cmd_stb), .MEM_CMD(mem_cmd),
		.RESULT_STB(result_stb), .PROD_INFO_1(prod_info_1), .PROD_INFO_2(prod_info_2));

	psr_mem_model mem (.mclk(mclk), .nrst(nrst), .slow(slow), .mem_cmd_stb(mem_cmd_stb),
		.mem_cmd(mem_cmd), .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data));

	always #2 mclk = ~mclk;

	////////////////////////////////////////////////////////////////////////
	// tolerance covers the rotator's last-bit error on angles and lengths
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input int tol);
		logic [15:0] d;
		d = seen - exp;
		checked++;
		if (!((seen === exp) || (tol > 0 && !$isunknown(seen) && (d <= 16'(tol) || d >= 16'(-tol)))))
		begin
			mismatches++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [7:0] crc8(input logic [15:0] w);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 15; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
		return c;
	endfunction : crc8

	task automatic rd(input logic [7:0] a, input logic [15:0] e, input int tol);
		@(posedge mclk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge mclk);
		#1;
		reg_rd = 1'b0;
		check({15'h0000, reg_rvalid}, 16'h0001, 0);
		check(reg_rdata, e, tol);
		if (tol == 0)
			check({8'h00, reg_rcrc}, (a >= ADR_CH0 && a <= ADR_CH2) ? {8'h00, crc8(e)} : 16'h0000, 0);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge mclk);
		#1;
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge mclk);
		#1;
		reg_wr = 1'b0;
	endtask : wr

	// one sample; a second one offered mid-run must be dropped
	task automatic run(input logic [15:0] cfg, input psr_pix_t p, input int n);
		int k;
		@(posedge mclk);
		#1;
		setup_cfg = cfg;
		smp = p;
		smp_valid = 1'b1;
		@(posedge mclk);
		#1;
		smp_valid = 1'b0;
		k = 0;
		while (result_stb !== 1'b1 && k < 200)
		begin
			smp_valid = (k == 4);
			smp = (k == 4) ? ~p : p;
			dec = (k == 4 || k == 5) ? ~dec : dec;
			@(posedge mclk);
			#1;
			k++;
		end
		check(16'(k), 16'(18 * n + 1), 0);
	endtask : run

	task automatic tcase(input logic [15:0] cfg, input int n, input logic [15:0] g,
		input psr_pix_t p, input logic [15:0] e0, input logic [15:0] e1,
		input logic [15:0] e2, input int t);
		joy_gain = g;
		run(cfg, p, n);
		rd(ADR_CH0, e0, t);
		rd(ADR_CH1, e1, t);
		rd(ADR_CH2, e2, 0);
	endtask : tcase

	task automatic results;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////////
	// watchdog: the sequence needs well under 2000 cycles
	initial
	begin
		#20000;
		mismatches++;
		results();
	end

	initial
	begin
		repeat (3) @(posedge mclk);
		#1;
		nrst = 1'b1;
		repeat (30) @(posedge mclk); // self-test pass first
		#1;
		check(prod_info_1, 16'h1111, 0);
		check(prod_info_2, 16'h2222, 0);
		rd(ADR_HWID, 16'h6B2D, 0);
		rd(ADR_UNUSED, 16'h0000, 0);
		rd(ADR_SLEEP, 16'h0000, 0);
		wr(ADR_SLEEP, SLEEP_KEY);
		check({15'h0000, sleep_req}, 16'h0001, 0);
		wr(ADR_SLEEP, 16'h1234);
		check({15'h0000, sleep_req}, 16'h0000, 0);
		// fast then slow memory answers
		wr(ADR_MEM, 16'hC3A5);
		check({15'h0000, mem_cmd_stb}, 16'h0001, 0);
		check(mem_cmd, 16'hC3A5, 0);
		repeat (6) @(posedge mclk);
		rd(ADR_MEM, 16'h3C5A, 0);
		slow = 1'b1;
		wr(ADR_MEM, 16'h0F0F);
		rd(ADR_MEM, 16'h0F0F, 0);
		repeat (12) @(posedge mclk);
		rd(ADR_MEM, 16'hF0F0, 0);
		// sticky fault words, cleared by reading
		@(posedge mclk);
		#1;
		fault_in0 = 16'h0080;
		fault_in1 = 16'h0100;
		@(posedge mclk);
		#1;
		fault_in0 = 16'h0000;
		fault_in1 = 16'h0000;
		rd(ADR_FLT0, 16'h0080, 0);
		rd(ADR_FLT0, 16'h0000, 0);
		rd(ADR_FLT1, 16'h0100, 0);
		// setups: cfg, passes, gain, cells, channel 0, 1, 2, tolerance
		tcase(16'h0001, 1, 16'h0, '{16'h1000, 0, 0, 0, 0, 0}, 16'h8000, 16'h1000, 0, 16);
		tcase(16'h0002, 1, 16'h0, '{0, 0, 0, 0, 16'h1000, 0}, 16'h4000, 16'h1000, 0, 16);
		tcase(16'h0003, 1, 16'h0, '{0, 0, 0, 16'h1000, 16'h0800, 16'h1000}, 16'h2000, 16'h16A1, 0, 16);
		tcase(16'h0013, 1, 16'h0, '{0, 0, 0, 0, 16'h1000, 16'h0800}, 16'h4000, 16'h1000, 0, 16);
		tcase(16'h0004, 1, 16'h0, '{16'h1000, 0, 16'h1000, 0, 0, 0}, 16'h0000, 16'h1000, 0, 16);
		tcase(16'h0024, 1, 16'h0, '{16'h1000, 0, 16'h1000, 0, 0, 0}, 16'h2000, 16'h16A1, 0, 16);
		tcase(16'h0044, 1, 16'h0, '{16'h1000, 0, 16'h1000, 0, 0, 0}, 16'h4000, 16'h1000, 0, 16);
		tcase(16'h0008, 1, 16'h0, '{16'h1000, 16'h2000, 0, 16'h3000, 16'h2000, 0}, 16'h2000, 16'h2D41, 0, 16);
		tcase(16'h0085, 2, 16'h0, '{16'h1000, 16'hF000, 16'h1000, 0, 0, 0}, 16'h2000, 16'h6000, 0, 16);
		tcase(16'h0086, 4, 16'h0, '{16'h1000, 16'h1000, 0, 0, 0, 0}, 16'h2000, 16'h4000, 0, 16);
		tcase(16'h0086, 4, 16'h1000, '{16'h1000, 16'h1000, 16'h1000, 0, 0, 0}, 16'h26EC, 16'h26EC, 0, 16);
		tcase(16'h0007, 1, 16'h0, '{16'h1000, 0, 0, 0, 0, 0}, 16'h1357, 16'h2468, 16'h0ACE, 0);
		tcase(16'h0003, 1, 16'h0, '{0, 0, 0, 0, 0, 0}, 16'h0000, 16'h0000, 0, 16);
		wr(ADR_CH0, 16'hFFFF);
		rd(ADR_CH0, 16'h0000, 0);
		rd(ADR_DEC1, 16'h1357, 0);
		rd(ADR_DEC2, 16'h2468, 0);
		rd(ADR_DEC3, 16'h0ACE, 0);
		results();
	end
endmodule : position_sensor_result_path_tb
`default_nettype wire

// ---- sim/psr_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// memory side of the access channel: answers the latest command once, fast or slow; a new command replaces a pending one
module psr_mem_model (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic slow,
	input wire logic mem_cmd_stb,
	input wire logic [15:0] mem_cmd,
	output logic mem_rsp_valid,
	output logic [15:0] mem_rsp_data
);
	int cnt_q;
	logic [15:0] cmd_q;
	logic [15:0] pat_q;

	////////////////////////////////////////////////////////////////////////
	// answer is the inverted command; outside answers the data wanders
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_q <= 0;
			cmd_q <= 16'h0000;
			pat_q <= 16'h0001;
			mem_rsp_valid <= 1'b0;
			mem_rsp_data <= 16'h0000;
		end
		else
		begin
			pat_q <= pat_q + 16'h3C5B; // never looks like a held answer
			mem_rsp_valid <= 1'b0;
			mem_rsp_data <= pat_q;
			if (mem_cmd_stb)
			begin
				cmd_q <= mem_cmd;
				cnt_q <= slow ? 6 : 1;
			end
			else if (cnt_q == 1)
			begin
				mem_rsp_valid <= 1'b1;
				mem_rsp_data <= ~cmd_q;
				cnt_q <= 0;
			end
			else if (cnt_q > 1)
				cnt_q <= cnt_q - 1;
		end
	end
endmodule : psr_mem_model
`default_nettype wire
